/* cft_alu.sv */
`timescale 1ns/1ps
module cft_alu (
  // Operation select and operands
  input  wire logic       asr_i,
  input  wire logic [7:0] dst_i,
  input  wire logic [7:0] src_i,
  input  wire logic [5:0] stat_i,
  // Result and new arithmetic flags
  output logic      [7:0] res_o,
  output logic      [5:0] stat_o
);
  import cft_pkg::*;

  wire logic [7:0] res_w;
  wire logic       c_w;

  assign res_w = asr_i ? {dst_i[7], dst_i[7:1]} : (dst_i ^ src_i); // RL9 RL10
  assign c_w   = asr_i ? dst_i[0] : stat_i[5];                     // RL9 RL10

  assign res_o  = res_w;
  // Order inside the six bits is C Z S V D H; V is cleared, D and H pass.
  assign stat_o = {c_w, (res_w == 8'h00), res_w[7], 1'b0, stat_i[1:0]}; // RL9 RL10

endmodule : cft_alu

/* cft_flags_core.sv */
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
// Operation
// RL1: Six status flags follow latest ALU-type operation.
// RL2: Carry, overflow, zero, sign offered as jump conditions.
// RL3: Half-carry and decimal-adjust never offered to jumps.
// RL4: User flags change only by explicit instruction; the code also takes them from a bus write to the flags register.
// RL5: User flags uninitialised and untouched by reset.
// RL6: Interrupts and traps push flags onto stack.
// RL7: Interrupt return reloads flags from stack.
// RL8: Trap: SP-2, PC, SP-1, flags, vector; 6 cycles.
// RL9: Arithmetic shift right keeps bit 7, bit 0 to carry.
// RL10: Exclusive-OR writes back, clears overflow, keeps carry.
// RL11: Flag bits from 7: C Z S V D H U2 U1.
module cft_flags_core (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 sys_rst_i,
  // AHB-Lite slave
  input  wire logic                 hsel_i,
  input  wire logic [31:0]          haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic      [31:0]          hrdata_o,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  // Decoder side
  input  wire cft_pkg::cft_instr_type instr_i,
  input  wire cft_pkg::cft_fupd_type  fupd_i,
  input  wire cft_pkg::cft_uflag_type uflag_i,
  input  wire logic                 irq_entry_i,
  input  wire logic                 illegal_i,
  input  wire logic                 interrupt_return_i,
  input  wire logic [15:0]          pc_i,
  input  wire logic [15:0]          irq_vec_i,
  output logic      [7:0]           result_o,
  output logic                      result_vld_o,
  output cft_pkg::cft_cond_type     cond_o,
  output logic      [7:0]           flags_o,
  output logic                      busy_o,
  output logic      [15:0]          pc_o,
  output logic                      pc_load_o,
  // Stack memory
  output cft_pkg::cft_stk_type      stk_o,
  input  wire logic [15:0]          stk_rdata_i
);
  import cft_pkg::*;

  function automatic logic op_is_xor(input logic [7:0] op);
    op_is_xor = ((op >= CFT_OP_XOR_LO) && (op <= CFT_OP_XOR_HI)) ||
                (op == CFT_OP_XORX_ER) || (op == CFT_OP_XORX_IM);
  endfunction : op_is_xor

  function automatic logic op_is_asr(input logic [7:0] op);
    op_is_asr = (op == CFT_OP_ASR_REG) || (op == CFT_OP_ASR_IND);
  endfunction : op_is_asr

  // State.
  cft_state_type state_reg;
  cft_state_type state_next;
  logic [5:0]    stat_reg;
  logic [5:0]    stat_next;
  logic [1:0]    user_reg;
  logic [1:0]    user_next;
  logic [15:0]   sp_reg;
  logic [15:0]   sp_next;
  logic [15:0]   pc_reg;
  logic [15:0]   pc_next;
  logic [15:0]   vec_reg;
  logic [15:0]   vec_next;
  logic [7:0]    res_reg;
  logic [7:0]    res_next;
  logic          rvld_reg;
  logic          rvld_next;
  logic          pcl_reg;
  logic          pcl_next;
  logic          busy_reg;
  cft_stk_type   stk_reg;
  cft_stk_type   stk_next;

  // Bus slave state.
  logic          dph_wr_reg;
  logic [7:0]    dph_addr_reg;
  logic [31:0]   hrdata_reg;
  logic          hready_reg;
  logic          hresp_reg;

  // Decoding.
  wire logic        bus_take;
  wire logic        bw_flags;
  wire logic        bw_sp;
  wire logic        bw_pc;
  wire logic        is_alu;
  wire logic        is_trap;
  wire logic        trap_evt;
  wire logic [7:0]  flags_w;
  wire logic [7:0]  alu_res;
  wire logic [5:0]  alu_stat;
  wire logic [31:0] rd_mux;

  assign bus_take = hsel_i & hready_i & htrans_i[1];
  assign bw_flags = dph_wr_reg & (dph_addr_reg == CFT_ADDR_FLAGS);
  assign bw_sp    = dph_wr_reg & (dph_addr_reg == CFT_ADDR_SP);
  assign bw_pc    = dph_wr_reg & (dph_addr_reg == CFT_ADDR_PC);
  assign is_alu   = instr_i.valid & (op_is_xor(instr_i.opcode) | op_is_asr(instr_i.opcode));
  assign is_trap  = instr_i.valid & (instr_i.opcode == CFT_OP_TRAP);
  assign trap_evt = irq_entry_i | illegal_i;
  assign flags_w  = {stat_reg, user_reg}; // RL11

  assign rd_mux =
    (haddr_i[7:0] == CFT_ADDR_FLAGS) ? {24'h000000, flags_w} :
    (haddr_i[7:0] == CFT_ADDR_SP)    ? {16'h0000, sp_reg} :
    (haddr_i[7:0] == CFT_ADDR_PC)    ? {16'h0000, pc_reg} :
    (haddr_i[7:0] == CFT_ADDR_STAT)  ? {23'h000000, res_reg, busy_reg} :
                                       32'h00000000;

  cft_alu u_alu (
    .asr_i  (op_is_asr(instr_i.opcode)),
    .dst_i  (instr_i.dst),
    .src_i  (instr_i.src),
    .stat_i (stat_reg),
    .res_o  (alu_res),
    .stat_o (alu_stat)
  );

  // Next-state logic. Core events are applied after bus writes and win.
  always_comb begin
    state_next = state_reg;
    stat_next  = stat_reg;
    user_next  = user_reg;
    sp_next    = sp_reg;
    pc_next    = pc_reg;
    vec_next   = vec_reg;
    res_next   = res_reg;
    rvld_next  = 1'b0;
    pcl_next   = 1'b0;
    stk_next   = '0;
    if (bw_flags) begin
      stat_next = hwdata_i[7:2];
      user_next = hwdata_i[1:0];
    end
    if (bw_sp) begin
      sp_next = hwdata_i[15:0];
    end
    if (bw_pc) begin
      pc_next = hwdata_i[15:0];
    end
    case (state_reg)
      CFT_IDLE: begin
        if (fupd_i.valid) begin
          stat_next = (stat_next & ~fupd_i.mask) | (fupd_i.value & fupd_i.mask); // RL1
        end
        user_next = (user_next & ~uflag_i.mask) | (uflag_i.value & uflag_i.mask); // RL4
        if (trap_evt) begin
          vec_next   = irq_vec_i;
          pc_next    = pc_i;
          state_next = CFT_T1; // RL6
        end else if (interrupt_return_i) begin
          state_next = CFT_R1; // RL7
        end else if (is_trap) begin
          vec_next   = {8'h00, instr_i.src};
          pc_next    = pc_i;
          state_next = CFT_T1; // RL8
        end else if (is_alu) begin
          res_next  = alu_res; // RL9 RL10
          rvld_next = 1'b1;
          stat_next = alu_stat; // RL1
        end
      end
      CFT_T1: begin
        sp_next    = sp_reg - CFT_SP_STEP2; // RL8
        state_next = CFT_T2;
      end
      CFT_T2: begin
        stk_next.we    = 1'b1;
        stk_next.word  = 1'b1;
        stk_next.addr  = sp_reg;
        stk_next.wdata = pc_reg; // RL8
        sp_next        = sp_reg - CFT_SP_STEP1;
        state_next     = CFT_T3;
      end
      CFT_T3: begin
        stk_next.we    = 1'b1;
        stk_next.addr  = sp_reg;
        stk_next.wdata = {8'h00, flags_w}; // RL6 RL8
        state_next     = CFT_T4;
      end
      CFT_T4: begin
        stk_next.re   = 1'b1;
        stk_next.word = 1'b1;
        stk_next.addr = vec_reg; // RL8
        state_next    = CFT_T5;
      end
      CFT_T5: begin
        state_next = CFT_T6;
      end
      CFT_T6: begin
        pc_next    = stk_rdata_i; // RL8
        pcl_next   = 1'b1;
        state_next = CFT_IDLE;
      end
      CFT_R1: begin
        stk_next.re   = 1'b1;
        stk_next.addr = sp_reg;
        sp_next       = sp_reg + CFT_SP_STEP1;
        state_next    = CFT_R2;
      end
      CFT_R2: begin
        stk_next.re   = 1'b1;
        stk_next.word = 1'b1;
        stk_next.addr = sp_reg;
        state_next    = CFT_R3;
      end
      CFT_R3: begin
        stat_next  = stk_rdata_i[7:2]; // RL7
        user_next  = stk_rdata_i[1:0]; // RL7
        state_next = CFT_R4;
      end
      CFT_R4: begin
        pc_next    = stk_rdata_i;
        sp_next    = sp_reg + CFT_SP_STEP2;
        pcl_next   = 1'b1;
        state_next = CFT_IDLE;
      end
      default: begin
        state_next = CFT_IDLE;
      end
    endcase
  end

  // The sequencer state and busy move together, so busy_o never lags the sequence.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_reg <= CFT_IDLE;
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_reg  <= (state_next != CFT_IDLE);
    end
  end

  // Arithmetic flags; the user flags live in their own register below.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      stat_reg <= CFT_STAT_RST;
    end else begin
      stat_reg <= stat_next; // RL1
    end
  end

  // Stack pointer, program counter and the captured trap vector.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sp_reg  <= CFT_SP_RST;
      pc_reg  <= CFT_PC_RST;
      vec_reg <= CFT_PC_RST;
    end else begin
      sp_reg  <= sp_next;
      pc_reg  <= pc_next;
      vec_reg <= vec_next;
    end
  end

  // Last result of a shift or exclusive-OR; it stands until the next one.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      res_reg <= CFT_RES_RST;
    end else begin
      res_reg <= res_next;
    end
  end

  // One-cycle pulses for a new result and a new program counter.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rvld_reg <= 1'b0;
      pcl_reg  <= 1'b0;
    end else begin
      rvld_reg <= rvld_next;
      pcl_reg  <= pcl_next;
    end
  end

  // Stack requests last exactly one cycle; an idle cycle drives all zeros.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      stk_reg <= '0;
    end else begin
      stk_reg <= stk_next;
    end
  end

  // The user flags carry no reset and keep their value through it.
  always_ff @(posedge mclk_i) begin
    user_reg <= user_next; // RL5
  end

  // Zero-wait AHB-Lite slave; read data are taken at the address phase.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      dph_wr_reg   <= 1'b0;
      dph_addr_reg <= 8'h00;
    end else begin
      dph_wr_reg   <= bus_take & hwrite_i;
      dph_addr_reg <= haddr_i[7:0];
    end
  end

  // Read data stand through the data phase and until the next read is taken.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      hrdata_reg <= 32'h00000000;
    end else if (bus_take & ~hwrite_i) begin
      hrdata_reg <= rd_mux;
    end
  end

  // The slave never inserts a wait state and always answers OKAY.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      hready_reg <= 1'b1;
      hresp_reg  <= 1'b0;
    end else begin
      hready_reg <= 1'b1;
      hresp_reg  <= 1'b0;
    end
  end

  assign hrdata_o     = hrdata_reg;
  assign hreadyout_o  = hready_reg;
  assign hresp_o      = hresp_reg;
  assign result_o     = res_reg;
  assign result_vld_o = rvld_reg;
  assign cond_o.c     = stat_reg[5]; // RL2
  assign cond_o.z     = stat_reg[4]; // RL2
  assign cond_o.s     = stat_reg[3]; // RL2
  assign cond_o.v     = stat_reg[2]; // RL2 RL3
  assign flags_o      = flags_w;
  assign busy_o       = busy_reg;
  assign pc_o         = pc_reg;
  assign pc_load_o    = pcl_reg;
  assign stk_o        = stk_reg;

endmodule : cft_flags_core

/* cft_flags_core_checker.sv */
`timescale 1ns/1ps
module cft_flags_core_checker (
  // Clock and reset
  input wire logic                   mclk_i,
  input wire logic                   sys_rst_i,
  // Observed ports
  input wire logic [1:0]             htrans_i,
  input wire logic                   hwrite_i,
  input wire cft_pkg::cft_instr_type instr_i,
  input wire cft_pkg::cft_uflag_type uflag_i,
  input wire logic                   irq_entry_i,
  input wire logic                   illegal_i,
  input wire logic                   interrupt_return_i,
  input wire logic [7:0]             result_o,
  input wire logic                   result_vld_o,
  input wire cft_pkg::cft_cond_type  cond_o,
  input wire logic [7:0]             flags_o,
  input wire logic                   busy_o,
  input wire logic                   pc_load_o,
  input wire cft_pkg::cft_stk_type   stk_o,
  input wire logic [15:0]            stk_rdata_i
);
  import cft_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  wire op_go = !busy_o && !irq_entry_i && !illegal_i && !interrupt_return_i && instr_i.valid;
  wire xor_go = op_go && (instr_i.opcode inside {[CFT_OP_XOR_LO:CFT_OP_XORX_IM]});
  wire asr_go = op_go && (instr_i.opcode inside {CFT_OP_ASR_REG, CFT_OP_ASR_IND});
  wire trap_go = !busy_o && (irq_entry_i || illegal_i ||
                 (instr_i.valid && !interrupt_return_i && instr_i.opcode == CFT_OP_TRAP));
  wire bus_wr = htrans_i[1] && hwrite_i;
  chk_xor_result: assert property (xor_go |=> result_vld_o &&
    result_o == ($past(instr_i.dst) ^ $past(instr_i.src)) && !flags_o[CFT_BIT_V] &&
    flags_o[CFT_BIT_Z] == (result_o == 8'h00) && $stable(flags_o[CFT_BIT_C]))
    else $error("xor result or flags wrong");
  chk_asr_result: assert property (asr_go |=> result_vld_o &&
    result_o == {$past(instr_i.dst[7]), $past(instr_i.dst[7:1])} &&
    flags_o[CFT_BIT_C] == $past(instr_i.dst[0]) && flags_o[CFT_BIT_S] == result_o[7])
    else $error("shift result or flags wrong");
  chk_cond_map: assert property (cond_o == flags_o[7:4])
    else $error("jump conditions differ from flags");
  chk_trap_time: assert property (trap_go |=> busy_o ##6 pc_load_o)
    else $error("trap length wrong");
  chk_trap_keep: assert property (trap_go |=> ##1 $stable(flags_o) [*6])
    else $error("trap changed flags");
  chk_flag_push: assert property (stk_o.we && !stk_o.word |-> stk_o.wdata[7:0] == flags_o)
    else $error("pushed byte is not the flags");
  chk_interrupt_return_load: assert property (stk_o.re && !stk_o.word |=> ##1
    flags_o == $past(stk_rdata_i[7:0])) else $error("return did not reload flags");
  chk_user_keep: assert property (!busy_o && uflag_i.mask == 2'b00 && !interrupt_return_i &&
    !bus_wr |=> $stable(flags_o[1:0])) else $error("user flags changed");
  cover property (trap_go);
  cover property (xor_go);
  cover property (asr_go ##1 result_vld_o);
  cover property (interrupt_return_i && !busy_o && !irq_entry_i && !illegal_i ##5 pc_load_o);
endmodule : cft_flags_core_checker

bind cft_flags_core cft_flags_core_checker u_chk (.mclk_i, .sys_rst_i, .htrans_i, .hwrite_i,
  .instr_i, .uflag_i, .irq_entry_i, .illegal_i, .interrupt_return_i, .result_o, .result_vld_o, .cond_o,
  .flags_o, .busy_o, .pc_load_o, .stk_o, .stk_rdata_i);

/* cft_flags_core_test.sv */
`timescale 1ns/1ps
module cft_flags_core_test;
  import cft_pkg::*;
  logic          mclk_i = 0, sys_rst_i = 1, hsel_i = 1, hwrite_i = 0;
  logic [31:0]   haddr_i = '0, hwdata_i = '0, hrdata_o, seed = 32'hb00b, rd;
  logic [1:0]    htrans_i = '0;
  logic [2:0]    hsize_i = 3'h2;
  cft_instr_type instr_i = '0;
  cft_fupd_type  fupd_i = '0;
  cft_uflag_type uflag_i = '{2'h3, 2'h1};
  logic          irq_entry_i = 0, illegal_i = 0, interrupt_return_i = 0;
  logic [15:0]   pc_i = '0, irq_vec_i = '0, pc_o, stk_rdata_i, msp, v, spc;
  logic [7:0]    result_o, flags_o, mf, sf, r;
  logic          hreadyout_o, hresp_o, result_vld_o, busy_o, pc_load_o;
  cft_cond_type  cond_o;
  cft_stk_type   stk_o;
  int            num_errors = 0, tests_run = 0, cyc = 0, n;
  logic [7:0]    ops [10] = '{8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'hb8, 8'hb9, 8'hd0, 8'hd1};
  cft_flags_core dut (.mclk_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .instr_i, .fupd_i,
    .uflag_i, .irq_entry_i, .illegal_i, .interrupt_return_i, .pc_i, .irq_vec_i, .result_o, .result_vld_o,
    .cond_o, .flags_o, .busy_o, .pc_o, .pc_load_o, .stk_o, .stk_rdata_i);
  cft_stack_model stk (.mclk_i, .stk_i(stk_o), .rdata_o(stk_rdata_i));
  initial forever #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      close_out();
    end
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk_i);
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask : ahb
  task automatic fu(input logic [5:0] x);
    @(posedge mclk_i);
    fupd_i <= '{1'b1, 6'h3f, x};
    @(posedge mclk_i);
    fupd_i <= '0;
    mf[7:2] = x;
    #1;
    chk(flags_o, mf);
  endtask : fu
  task automatic ufl(input logic [1:0] x);
    @(posedge mclk_i);
    uflag_i <= '{2'h3, x};
    @(posedge mclk_i);
    uflag_i <= '0;
    mf[1:0] = x;
    #1;
    chk(flags_o, mf);
  endtask : ufl
  task automatic op(input logic [7:0] o, input logic [7:0] d, input logic [7:0] s);
    @(posedge mclk_i);
    instr_i <= '{1'b1, o, d, s};
    @(posedge mclk_i);
    instr_i <= '0;
    r = o[6] ? {d[7], d[7:1]} : d ^ s;
    if (o[6]) mf[7] = d[0];
    mf[6:4] = {r == 8'h00, r[7], 1'b0};
    #1;
    chk(result_vld_o, 1);
    chk(result_o, r);
    chk(flags_o, mf);
    chk(cond_o, mf[7:4]);
  endtask : op
  task automatic wld();
    n = 0;
    #1;
    while (pc_load_o !== 1'b1 && n < 20) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
  endtask : wld
  task automatic trap(input int k);
    seed = nx(seed);
    v = {8'h00, seed[7:0]};
    @(posedge mclk_i);
    pc_i <= seed[31:16];
    irq_vec_i <= v;
    if (k == 0) instr_i <= '{1'b1, CFT_OP_TRAP, 8'h00, v[7:0]};
    else if (k == 1) irq_entry_i <= 1;
    else illegal_i <= 1;
    @(posedge mclk_i);
    instr_i <= '0;
    irq_entry_i <= 0;
    illegal_i <= 0;
    wld();
    chk(n, 6);
    chk(busy_o, 0);
    chk(pc_o, {stk.rb(v + 16'h1), stk.rb(v)});
    chk(flags_o, mf);
    chk({stk.rb(msp - 16'h1), stk.rb(msp - 16'h2)}, pc_i);
    chk(stk.rb(msp - 16'h3), mf);
    msp = msp - 16'h3;
    ahb(0, CFT_ADDR_SP, 0);
    chk(rd, {16'h0, msp});
  endtask : trap
  initial begin
    mf = 8'h00;
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 0;
    ufl(2'h1);
    ahb(1, CFT_ADDR_SP, 32'h200);
    msp = 16'h0200;
    for (int j = 0; j < 20; j++) begin
      seed = nx(seed);
      fu(seed[5:0]);
      seed = nx(seed);
      op(ops[j % 10], seed[7:0], seed[15:8]);
    end
    ahb(0, CFT_ADDR_STAT, 0);
    chk(rd, {23'h0, r, 1'b0});
    $display("test alu done");
    for (int k = 0; k < 3; k++) begin
      trap(k);
      sf = mf;
      spc = pc_i;
      fu(~mf[7:2]);
      ufl(~mf[1:0]);
      @(posedge mclk_i);
      interrupt_return_i <= 1;
      @(posedge mclk_i);
      interrupt_return_i <= 0;
      wld();
      chk(n, 4);
      mf = sf;
      msp = msp + 16'h3;
      chk(flags_o, mf);
      chk(pc_o, spc);
      ahb(0, CFT_ADDR_SP, 0);
      chk(rd, {16'h0, msp});
      $display("test trap kind %0d done", k);
    end
    ufl(2'h2);
    @(posedge mclk_i);
    sys_rst_i <= 1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 0;
    mf = {6'h00, mf[1:0]};
    #1;
    chk(flags_o, mf);
    ahb(0, CFT_ADDR_FLAGS, 0);
    chk(rd, {24'h0, mf});
    chk(hresp_o, 0);
    ahb(0, CFT_ADDR_SP, 0);
    chk(rd, {16'h0, CFT_SP_RST});
    ahb(0, 8'h10, 0);
    chk(rd, 0);
    $display("test reset done");
    close_out();
  end
endmodule : cft_flags_core_test

/* cft_pkg.sv */
package cft_pkg;

  // Bit positions of the flags inside the 8-bit flag register.
  localparam int unsigned CFT_BIT_C  = 7;
  localparam int unsigned CFT_BIT_Z  = 6;
  localparam int unsigned CFT_BIT_S  = 5;
  localparam int unsigned CFT_BIT_V  = 4;
  localparam int unsigned CFT_BIT_D  = 3;
  localparam int unsigned CFT_BIT_H  = 2;
  localparam int unsigned CFT_BIT_U2 = 1;
  localparam int unsigned CFT_BIT_U1 = 0;

  // Opcodes executed by this block.
  localparam logic [7:0] CFT_OP_ASR_REG  = 8'hd0;
  localparam logic [7:0] CFT_OP_ASR_IND  = 8'hd1;
  localparam logic [7:0] CFT_OP_XOR_LO   = 8'hb2;
  localparam logic [7:0] CFT_OP_XOR_HI   = 8'hb7;
  localparam logic [7:0] CFT_OP_XORX_ER  = 8'hb8;
  localparam logic [7:0] CFT_OP_XORX_IM  = 8'hb9;
  localparam logic [7:0] CFT_OP_TRAP     = 8'hf2;

  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] CFT_ADDR_FLAGS  = 8'h00;
  localparam logic [7:0] CFT_ADDR_SP     = 8'h04;
  localparam logic [7:0] CFT_ADDR_PC     = 8'h08;
  localparam logic [7:0] CFT_ADDR_STAT   = 8'h0c;

  // Values after reset.
  localparam logic [5:0]  CFT_STAT_RST   = 6'h00;
  localparam logic [15:0] CFT_SP_RST     = 16'h0000;
  localparam logic [15:0] CFT_PC_RST     = 16'h0000;
  localparam logic [7:0]  CFT_RES_RST    = 8'h00;

  // Stack pointer steps.
  localparam logic [15:0] CFT_SP_STEP1   = 16'h0001;
  localparam logic [15:0] CFT_SP_STEP2   = 16'h0002;

  // Instruction handed over by the decoder.
  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
    logic [7:0] dst;
    logic [7:0] src;
  } cft_instr_type;

  // Flag update from arithmetic, logic, bit and rotate units elsewhere.
  typedef struct packed {
    logic       valid;
    logic [5:0] mask;
    logic [5:0] value;
  } cft_fupd_type;

  // Explicit set or clear of the user flags.
  typedef struct packed {
    logic [1:0] mask;
    logic [1:0] value;
  } cft_uflag_type;

  // Request to the stack memory.
  typedef struct packed {
    logic        we;
    logic        re;
    logic        word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cft_stk_type;

  // Conditions that a conditional jump may test.
  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
  } cft_cond_type;

  typedef enum logic [3:0] {
    CFT_IDLE,
    CFT_T1, CFT_T2, CFT_T3, CFT_T4, CFT_T5, CFT_T6,
    CFT_R1, CFT_R2, CFT_R3, CFT_R4
  } cft_state_type;

endpackage : cft_pkg

/* cft_stack_model.sv */
`timescale 1ns/1ps
module cft_stack_model (
  // Clock
  input  wire logic                 mclk_i,
  // Stack port
  input  wire cft_pkg::cft_stk_type stk_i,
  output logic      [15:0]          rdata_o
);
  import cft_pkg::*;
  logic [7:0] mem [logic [15:0]];
  // Unwritten bytes answer a pattern that differs from address to address.
  function automatic logic [7:0] rb(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : (~a[7:0] ^ a[15:8]);
  endfunction : rb
  initial rdata_o = 16'h0000;
  always @(posedge mclk_i) begin
    if (stk_i.we) begin
      mem[stk_i.addr] = stk_i.wdata[7:0];
      if (stk_i.word) mem[stk_i.addr + 16'h0001] = stk_i.wdata[15:8];
    end
    // Read data stands one cycle only, then the port scrambles it.
    if (stk_i.re) rdata_o <= {stk_i.word ? rb(stk_i.addr + 16'h0001) : 8'h00, rb(stk_i.addr)};
    else rdata_o <= ~rdata_o;
  end
endmodule : cft_stack_model
